// file: pwmpd_pkg.sv
// Package for the pulse-divider and modulator block: register map, field
// layout, reset values, output modes and the pin bundle.
// Assumes 8-bit registers in the low byte of a 32-bit Avalon-MM word.
package pwmpd_pkg;

  // Register byte addresses, one aligned word each
  localparam logic [4:0] PWMPD_ADDR_TMR_CTRL = 5'h00;  // Companion timer control
  localparam logic [4:0] PWMPD_ADDR_TMR_CNT  = 5'h04;  // Companion timer count
  localparam logic [4:0] PWMPD_ADDR_PERIOD   = 5'h08;  // Period value
  localparam logic [4:0] PWMPD_ADDR_SD_CTRL  = 5'h0c;  // Shutoff control
  localparam logic [4:0] PWMPD_ADDR_MOD_CTRL = 5'h10;  // Modulator control
  localparam logic [4:0] PWMPD_ADDR_DB_CTRL  = 5'h14;  // Dead-band control
  localparam logic [4:0] PWMPD_ADDR_DUTY_HI  = 5'h18;  // Duty high byte

  // Timer control fields
  localparam int TMR_RUN_BIT  = 7;   // timer_run_enable
  localparam int TMR_CSEL_LSB = 5;   // timer_clock_select [6:5]
  localparam int TMR_POST_LSB = 2;   // timer_postscale [4:2]
  localparam int TMR_PRE_LSB  = 0;   // timer_prescale [1:0]

  // Shutoff control fields
  localparam int SD_FLAG_BIT = 7;    // shutoff_flag
  localparam int SD_TSEL_LSB = 4;    // shutoff_trigger_select [5:4]
  localparam int SD_PA_LSB   = 2;    // shutoff_state_pair_a [3:2]
  localparam int SD_PB_LSB   = 0;    // shutoff_state_pair_b [1:0]

  // Modulator control fields
  localparam int MOD_EN_BIT   = 7;   // modulation_enable
  localparam int DIV_EN_BIT   = 6;   // divider_enable
  localparam int MOD_DLO_LSB  = 4;   // duty_low_bits [5:4]
  localparam int MOD_MODE_LSB = 2;   // output_mode_select [3:2]
  localparam int MOD_POL_LSB  = 0;   // output_polarity_select [1:0]

  // Dead-band control fields
  localparam int DB_ARST_BIT = 7;    // auto_restart_enable
  localparam int DB_CNT_LSB  = 0;    // dead_band_count [6:0]

  // Reset values
  localparam logic [7:0] RST_TMR_CTRL = 8'h00;
  localparam logic [7:0] RST_TMR_CNT  = 8'h00;
  localparam logic [7:0] RST_PERIOD   = 8'hff;
  localparam logic [7:0] RST_SD_CTRL  = 8'h00;
  localparam logic [7:0] RST_MOD_CTRL = 8'h00;
  localparam logic [7:0] RST_DB_CTRL  = 8'h00;
  localparam logic [7:0] RST_DUTY_HI  = 8'h00;

  // Timer clock source codes
  localparam logic [1:0] CSEL_OSC = 2'b00;  // internal_osc_clock
  localparam logic [1:0] CSEL_LOW = 2'b01;  // low_speed_clock

  // Shutoff trigger source codes
  localparam logic [1:0] TSEL_OFF  = 2'b00;
  localparam logic [1:0] TSEL_FILT = 2'b01;
  localparam logic [1:0] TSEL_BOTH = 2'b10;
  localparam logic [1:0] TSEL_COMP = 2'b11;

  // Output mode encodings
  typedef enum logic [1:0] {
    PWMPD_SINGLE   = 2'b00,
    PWMPD_FULL_FWD = 2'b01,
    PWMPD_HALF     = 2'b10,
    PWMPD_FULL_REV = 2'b11
  } pwmpd_mode_t;

  // Output pin bundle: level and drive enable per pin
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } pwmpd_pins_t;

endpackage : pwmpd_pkg

// file: pwmpd_gen.sv
// Pulse divider and pulse-width modulator with dead band and auto shutoff.
// Assumes clock sources and trigger inputs arrive asynchronously on pins;
// the master follows Avalon-MM with waitrequest on the register port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Divider output toggles per postscaled period
// - Divider enable starts, clear stops divider
// - Period register sets modulation period length
// - Duty is 10 bits: high byte, low two
// - Period match sets output, clears count
// - New duty loads at period end, or while modulation is stopped
// - Duty above period keeps output active
// - Modulation enable starts and stops modulation
// - Single, dual, quad drive one, two, four
// - Mode field and polarity field select outputs
// - Seven-bit dead band delay in timer clocks
// - Trigger select 00 disables auto shutoff
// - Trigger sets flag; pins take shutoff levels
// - Two shutoff fields set pair levels
// - Auto restart clears flag by hardware
// - Modulation resumes at next period start
// - Mode codes single, forward, half, reverse
// - Polarity codes set pair active levels
// - Dead band delays inactive to active edge
// - Shutoff codes low, high, split pair
module pwmpd_gen (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic [4:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output var  logic [31:0]          avs_readdata,
  output var  logic                 avs_waitrequest,
  input  wire logic                 internal_osc_clock,
  input  wire logic                 low_speed_clock,
  input  wire logic                 comparator_out,
  input  wire logic                 filter_input,
  output var  pwmpd_pkg::pwmpd_pins_t pins
);
  import pwmpd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [3:0]  sync1_r;        // First synchroniser stage
  logic [3:0]  sync2_r;        // Second synchroniser stage
  logic [1:0]  clk_d_r;        // Delayed clock levels for edge detect
  logic        waitreq_r;      // Bus wait state
  logic [31:0] rdata_r;        // Read data
  logic [7:0]  tmr_ctrl_r;     // Timer control
  logic [7:0]  count_r;        // Timer count
  logic [7:0]  period_r;       // Period value
  logic [5:0]  sd_ctrl_r;      // Shutoff control without flag
  logic        flag_r;         // Shutoff flag
  logic [7:0]  mod_ctrl_r;     // Modulator control
  logic [7:0]  db_ctrl_r;      // Dead-band control
  logic [7:0]  duty_hi_r;      // Duty high byte
  logic [2:0]  pre_cnt_r;      // Prescale counter
  logic [2:0]  post_cnt_r;     // Postscale counter
  logic        div_out_r;      // Divider square wave
  logic [9:0]  duty_buf_r;     // Buffered duty value
  logic        mod_act_r;      // Modulated waveform, active sense
  logic        shut_out_r;     // Pins held in shutoff levels
  logic [3:0]  db_act_r;       // Dead-band delayed active states
  pwmpd_pins_t pins_r;         // Registered pins
  logic        req;            // Bus request present
  logic        wr_en;          // Write takes effect this edge
  logic        tick;           // Timer clock event
  logic        adv;            // Count advance
  logic        period_end;     // Count matched period
  logic [2:0]  pre_max;        // Prescale factor minus one
  logic [2:0]  frac;           // Prescale phase in eighths of an advance
  logic [3:0]  step;           // Eighths gained per tick
  logic [11:0] pos;            // Position after this tick, in eighths
  logic [11:0] duty_end;       // Pulse end, twice duty plus eight, in eighths
  logic [9:0]  duty_nxt;       // Duty from registers
  logic        trig;           // Selected shutoff trigger
  logic        mod_en;         // modulation_enable
  logic        div_en;         // divider_enable
  logic [3:0]  act;            // Raw active state per pin
  logic [3:0]  drv;            // Pins driven in this mode
  logic [3:0]  inv;            // Active-low pins
  logic [3:0]  shut_lvl;       // Shutoff level per pin
  pwmpd_pins_t pins_nxt;       // Next pin bundle
  logic [31:0] rdata_nxt;      // Next read data

  assign req    = avs_read | avs_write;
  assign wr_en  = avs_write & ~waitreq_r & avs_byteenable[0];
  assign mod_en = mod_ctrl_r[MOD_EN_BIT];
  assign div_en = mod_ctrl_r[DIV_EN_BIT];
  assign duty_nxt = {duty_hi_r, mod_ctrl_r[MOD_DLO_LSB +: 2]};

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pin inputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      clk_d_r <= 2'h0;
    end else begin
      sync1_r <= {filter_input, comparator_out, low_speed_clock, internal_osc_clock};
      sync2_r <= sync1_r;
      clk_d_r <= sync2_r[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then answer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      waitreq_r <= 1'b1;
      rdata_r   <= 32'h0;
    end else begin
      waitreq_r <= ~(req & waitreq_r);
      if (avs_read && waitreq_r) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // Read-back mux, unmapped reads as zero
  always_comb begin
    rdata_nxt = 32'h0;
    case (avs_address)
      PWMPD_ADDR_TMR_CTRL: rdata_nxt[7:0] = tmr_ctrl_r;
      PWMPD_ADDR_TMR_CNT:  rdata_nxt[7:0] = count_r;
      PWMPD_ADDR_PERIOD:   rdata_nxt[7:0] = period_r;
      PWMPD_ADDR_SD_CTRL:  rdata_nxt[7:0] = {flag_r, 1'b0, sd_ctrl_r};
      PWMPD_ADDR_MOD_CTRL: rdata_nxt[7:0] = mod_ctrl_r;
      PWMPD_ADDR_DB_CTRL:  rdata_nxt[7:0] = db_ctrl_r;
      PWMPD_ADDR_DUTY_HI:  rdata_nxt[7:0] = duty_hi_r;
      default:             rdata_nxt = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written control registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tmr_ctrl_r <= RST_TMR_CTRL;
      period_r   <= RST_PERIOD;
      sd_ctrl_r  <= RST_SD_CTRL[5:0];
      mod_ctrl_r <= RST_MOD_CTRL;
      db_ctrl_r  <= RST_DB_CTRL;
      duty_hi_r  <= RST_DUTY_HI;
    end else if (wr_en) begin
      case (avs_address)
        PWMPD_ADDR_TMR_CTRL: tmr_ctrl_r <= avs_writedata[7:0];
        PWMPD_ADDR_PERIOD:   period_r   <= avs_writedata[7:0];
        PWMPD_ADDR_SD_CTRL:  sd_ctrl_r  <= avs_writedata[5:0];
        PWMPD_ADDR_MOD_CTRL: mod_ctrl_r <= avs_writedata[7:0];
        PWMPD_ADDR_DB_CTRL:  db_ctrl_r  <= avs_writedata[7:0];
        PWMPD_ADDR_DUTY_HI:  duty_hi_r  <= avs_writedata[7:0];
        default:             ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer clock selection and prescale
  always_comb begin
    case (tmr_ctrl_r[TMR_CSEL_LSB +: 2])
      CSEL_OSC: tick = sync2_r[0] & ~clk_d_r[0];
      CSEL_LOW: tick = sync2_r[1] & ~clk_d_r[1];
      default:  tick = 1'b1;
    endcase
    tick = tick & tmr_ctrl_r[TMR_RUN_BIT];
    case (tmr_ctrl_r[TMR_PRE_LSB +: 2])
      2'b00:   begin pre_max = 3'd0; frac = 3'h0; step = 4'h8; end
      2'b01:   begin pre_max = 3'd1; frac = {pre_cnt_r[0], 2'b00}; step = 4'h4; end
      2'b10:   begin pre_max = 3'd3; frac = {pre_cnt_r[1:0], 1'b0}; step = 4'h2; end
      default: begin pre_max = 3'd7; frac = pre_cnt_r; step = 4'h1; end
    endcase
  end

  assign adv        = tick & (pre_cnt_r == pre_max);
  assign period_end = adv & (count_r == period_r);
  // Width scales with prescale: pulse lasts prescale*(duty+4)/4 ticks
  assign pos        = {1'b0, count_r, frac} + {8'h00, step};
  assign duty_end   = {1'b0, duty_buf_r, 1'b0} + 12'h008;

  // Prescale counter
  always_ff @(posedge clock) begin
    if (!rst_n || !tmr_ctrl_r[TMR_RUN_BIT]) begin
      pre_cnt_r <= 3'h0;
    end else if (tick) begin
      pre_cnt_r <= adv ? 3'h0 : pre_cnt_r + 3'h1;
    end
  end

  // Timer count: software write, clear on match, advance
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_r <= RST_TMR_CNT;
    end else if (wr_en && avs_address == PWMPD_ADDR_TMR_CNT) begin
      count_r <= avs_writedata[7:0];
    end else if (period_end) begin
      count_r <= 8'h00;
    end else if (adv) begin
      count_r <= count_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse divider: postscale then toggle
  always_ff @(posedge clock) begin
    if (!rst_n || !div_en) begin
      post_cnt_r <= 3'h0;
      div_out_r  <= 1'b0;
    end else if (period_end) begin
      // At or past the code, so a lowered postscale never wraps
      if (post_cnt_r >= tmr_ctrl_r[TMR_POST_LSB +: 3]) begin
        post_cnt_r <= 3'h0;
        div_out_r  <= ~div_out_r;
      end else begin
        post_cnt_r <= post_cnt_r + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duty buffer, loaded at period end or while stopped
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      duty_buf_r <= 10'h000;
    end else if (!mod_en || period_end) begin
      duty_buf_r <= duty_nxt;
    end
  end

  // Modulated waveform
  always_ff @(posedge clock) begin
    if (!rst_n || !mod_en) begin
      mod_act_r <= 1'b0;
    end else if (period_end) begin
      mod_act_r <= (duty_nxt != 10'h000);
    end else if (tick && pos >= duty_end) begin
      mod_act_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auto shutoff trigger and flag
  always_comb begin
    case (sd_ctrl_r[SD_TSEL_LSB +: 2])
      TSEL_FILT: trig = sync2_r[3];
      TSEL_BOTH: trig = sync2_r[3] | sync2_r[2];
      TSEL_COMP: trig = sync2_r[2];
      default:   trig = 1'b0;
    endcase
  end

  // Trigger set wins over any clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (trig && mod_en) begin
      flag_r <= 1'b1;
    end else if (wr_en && avs_address == PWMPD_ADDR_SD_CTRL) begin
      flag_r <= avs_writedata[SD_FLAG_BIT];
    end else if (db_ctrl_r[DB_ARST_BIT]) begin
      flag_r <= 1'b0;
    end
  end

  // Shutoff hold, released at a period boundary or when modulation is disabled
  always_ff @(posedge clock) begin
    if (!rst_n || !mod_en) begin
      shut_out_r <= 1'b0;
    end else if (flag_r) begin
      shut_out_r <= 1'b1;
    end else if (period_end) begin
      shut_out_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output steering per mode, polarity and shutoff levels
  always_comb begin
    case (pwmpd_mode_t'(mod_ctrl_r[MOD_MODE_LSB +: 2]))
      PWMPD_SINGLE:   begin act = {3'b000, mod_act_r}; drv = 4'b0001; end
      PWMPD_HALF:     begin act = {2'b00, ~mod_act_r, mod_act_r}; drv = 4'b0011; end
      PWMPD_FULL_FWD: begin act = {mod_act_r, 3'b001}; drv = 4'b1111; end
      PWMPD_FULL_REV: begin act = {2'b01, mod_act_r, 1'b0}; drv = 4'b1111; end
      default:        begin act = 4'b0000; drv = 4'b0000; end
    endcase
    inv = {mod_ctrl_r[MOD_POL_LSB], mod_ctrl_r[MOD_POL_LSB + 1],
           mod_ctrl_r[MOD_POL_LSB], mod_ctrl_r[MOD_POL_LSB + 1]};
  end

  // Dead band and shutoff level per pin
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      logic [6:0] db_cnt_r;  // Delay counter
      logic [1:0] sfield;    // Shutoff field of this pin's pair
      assign sfield = (gi % 2 == 0) ? sd_ctrl_r[SD_PA_LSB +: 2] : sd_ctrl_r[SD_PB_LSB +: 2];
      // Split code: first pin of pair low, second high
      assign shut_lvl[gi] = sfield[1] ? (gi >= 2) : sfield[0];
      always_ff @(posedge clock) begin
        if (!rst_n || !act[gi]) begin
          db_cnt_r     <= 7'h00;
          db_act_r[gi] <= 1'b0;
        end else if (db_cnt_r == db_ctrl_r[DB_CNT_LSB +: 7]) begin
          db_act_r[gi] <= 1'b1;
        end else if (tick) begin
          db_cnt_r <= db_cnt_r + 7'h01;
        end
      end
    end
  endgenerate

  // One function owns the pins at a time
  always_comb begin
    pins_nxt = '0;
    if (mod_en) begin
      pins_nxt.oe    = drv;
      pins_nxt.level = drv & (shut_out_r ? shut_lvl : (db_act_r ^ inv));
    end else if (div_en) begin
      pins_nxt.oe    = 4'b0001;
      pins_nxt.level = {3'b000, div_out_r};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pins_r <= '0;
    end else begin
      pins_r <= pins_nxt;
    end
  end

  assign pins            = pins_r;
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = waitreq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_BUS_ONE_WAIT: assert property (
    req && waitreq_r |=> !waitreq_r ##1 waitreq_r)
    else $error("bus answer not after exactly one wait cycle");
  AST_MATCH_CLEAR: assert property (
    period_end && !wr_en |=> count_r == 8'h00)
    else $error("count not cleared on period match");
  AST_ZERO_DUTY: assert property (
    period_end && mod_en && duty_nxt == 10'h000 && !wr_en |=> !mod_act_r)
    else $error("zero duty drove output active");
  AST_SET_ON_MATCH: assert property (
    period_end && mod_en && duty_nxt != 10'h000 && !wr_en |=> mod_act_r)
    else $error("output not set at period match");
  AST_DUTY_HOLD: assert property (
    mod_en && !period_end |=> $stable(duty_buf_r))
    else $error("duty buffer changed inside a period");
  AST_NEVER_LOW: assert property (
    mod_act_r && mod_en && !period_end && duty_buf_r > {period_r, 2'b11} && !wr_en
    |=> mod_act_r)
    else $error("output dropped with duty above period");
  AST_FLAG_SET: assert property (
    trig && mod_en |=> flag_r ##1 shut_out_r || !mod_en)
    else $error("trigger did not set flag and shutoff");
  AST_SHUT_LEVELS: assert property (
    shut_out_r && mod_en |=> pins_r.level == ($past(drv) & $past(shut_lvl)))
    else $error("pins not at shutoff levels");
  AST_RESUME_LATE: assert property (
    $fell(flag_r) && mod_en && $past(mod_en) |-> shut_out_r)
    else $error("outputs resumed before period start");
  AST_DIV_STOP: assert property (
    !div_en |=> !div_out_r)
    else $error("divider running while disabled");
  AST_SINGLE_PIN: assert property (
    mod_en && mod_ctrl_r[MOD_MODE_LSB +: 2] == 2'b00 |=> pins_r.oe == 4'b0001)
    else $error("single mode drove extra pins");
  AST_DB_DELAY: assert property (
    $rose(act[0]) && db_ctrl_r[DB_CNT_LSB +: 7] != 7'h00 |=> !db_act_r[0])
    else $error("dead band not applied on activation");

  COV_SHUTOFF: cover property (trig && mod_en ##1 flag_r);
  COV_DIV_TOGGLE: cover property (div_en && period_end ##1 $changed(div_out_r));
  COV_PERIOD: cover property (mod_en && period_end ##1 mod_act_r);
  COV_RESTART: cover property ($fell(shut_out_r) && mod_en);

endmodule : pwmpd_gen

`default_nettype wire

// file: pwmpd_load.sv
// Load model on the four output pins of the pulse block.
// Assumes one system clock; measures pin 0 seen through a pull-down load.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module pwmpd_load (
  input  wire logic                   clock,
  input  wire pwmpd_pkg::pwmpd_pins_t pins,
  output var  int                     rise_gap,
  output var  int                     high_len,
  output var  int                     edges
);
  import pwmpd_pkg::*;

  logic line0;            // Pin 0 as the load sees it
  logic prev = 1'b0;      // Last sampled level
  int   since_rise = 0;   // Cycles since last rising edge

  // Undriven pin falls to the pull-down level
  assign line0 = pins.oe[0] ? pins.level[0] : 1'b0;

  // Edge timing of pin 0
  always @(posedge clock) begin
    prev <= line0;
    since_rise <= since_rise + 1;
    if (line0 && !prev) begin
      rise_gap <= since_rise;
      since_rise <= 1;
      edges <= edges + 1;
    end
    if (!line0 && prev) high_len <= since_rise;
  end

  initial begin
    rise_gap = 0;
    high_len = 0;
    edges = 0;
  end
endmodule : pwmpd_load

`default_nettype wire

// file: test_pwm_pulse_divider_gen.sv
// Self-checking bench for the pulse divider and modulator block.
// Assumes the design package and the pin load model are compiled first.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end

////////////////////////////////////////////////////////////////////////////////
module test_pwm_pulse_divider_gen;
  import pwmpd_pkg::*;

  logic        clock = 1'b0;          // 50 MHz system clock
  logic        rst_n = 1'b0;          // Synchronous reset
  logic [4:0]  avs_address = 5'h00;   // Bus request lines
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        osc = 1'b0;            // Timer source, 4 clocks a cycle
  logic        lsc = 1'b0;            // Slow source, 16 clocks a cycle
  logic        cmp = 1'b0;            // Shutoff triggers
  logic        filt = 1'b0;
  pwmpd_pins_t pins;
  int          failures = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          rise_gap, high_len, edges, e0;
  logic [7:0]  rd;
  logic [7:0]  rst_t [7] = '{RST_TMR_CTRL, RST_TMR_CNT, RST_PERIOD, RST_SD_CTRL,
                            RST_MOD_CTRL, RST_DB_CTRL, RST_DUTY_HI};
  logic [3:0]  raw_t [4] = '{4'b0001, 4'b1001, 4'b0001, 4'b0110};  // Always-active levels
  logic [3:0]  oe_t  [4] = '{4'b0001, 4'b1111, 4'b0011, 4'b1111};  // Driven pins
  int          div_t [4] = '{32, 64, 64, 1024};                     // Divider periods
  logic [7:0]  dctl_t [4] = '{8'h80, 8'h84, 8'h81, 8'ha3};

  pwmpd_gen dut_u (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .internal_osc_clock(osc), .low_speed_clock(lsc),
    .comparator_out(cmp), .filter_input(filt), .pins(pins));

  pwmpd_load load_u (.clock(clock), .pins(pins), .rise_gap(rise_gap),
    .high_len(high_len), .edges(edges));

  // Clock
  initial begin
    forever #10 clock = ~clock;
  end

  // Timer sources and hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc[0]) osc <= ~osc;
    if (cyc[2:0] == 3'd7) lsc <= ~lsc;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  // Bus write, held until waitrequest sampled low
  task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_wr

  // Bus read, data taken at the accepting edge
  task automatic bus_rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    d = avs_readdata[7:0];
    avs_read <= 1'b0;
  endtask : bus_rd

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt

  // Verdict
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    wt(10);
    rst_n <= 1'b1;
    wt(1);
    // Reset values and refused accesses
    for (int i = 0; i < 7; i++) begin
      bus_rd(5'(i * 4), rd);
      `CHK(rd, rst_t[i])
    end
    bus_wr(5'h1c, 8'h5a);
    bus_rd(5'h1c, rd);
    `CHK(rd, 8'h00)
    avs_byteenable <= 4'h0;
    bus_wr(PWMPD_ADDR_PERIOD, 8'h12);
    avs_byteenable <= 4'hf;
    bus_rd(PWMPD_ADDR_PERIOD, rd);
    `CHK(rd, RST_PERIOD)
    $display("test registers done");
    // Divider periods over prescale, postscale and slow source
    bus_wr(PWMPD_ADDR_PERIOD, 8'h03);
    bus_wr(PWMPD_ADDR_MOD_CTRL, 8'h40);
    for (int i = 0; i < 4; i++) begin
      bus_wr(PWMPD_ADDR_TMR_CTRL, dctl_t[i]);
      wt(div_t[i] * 3);
      `CHK(rise_gap, div_t[i])
    end
    bus_wr(PWMPD_ADDR_TMR_CTRL, 8'h80);
    bus_wr(PWMPD_ADDR_MOD_CTRL, 8'h00);
    wt(4);
    e0 = edges;
    wt(100);
    `CHK(edges, e0)
    $display("test divider done");
    // Pulse widths, integer and fractional duty
    bus_wr(PWMPD_ADDR_PERIOD, 8'h09);
    bus_wr(PWMPD_ADDR_DUTY_HI, 8'h05);
    bus_wr(PWMPD_ADDR_MOD_CTRL, 8'h80);
    wt(150);
    `CHK(rise_gap, 40)
    `CHK(high_len, 24)
    bus_wr(PWMPD_ADDR_TMR_CTRL, 8'h82);
    bus_wr(PWMPD_ADDR_MOD_CTRL, 8'ha0);
    wt(600);
    `CHK(rise_gap, 160)
    `CHK(high_len, 104)
    bus_wr(PWMPD_ADDR_TMR_CTRL, 8'h80);
    bus_wr(PWMPD_ADDR_MOD_CTRL, 8'h80);
    bus_wr(PWMPD_ADDR_DUTY_HI, 8'h00);
    wt(100);
    e0 = edges;
    wt(100);
    `CHK(edges, e0)
    `CHK(pins.level[0], 1'b0)
    $display("test width done");
    // Dead band of two ticks on the half-bridge pair delays the rise only
    bus_wr(PWMPD_ADDR_DUTY_HI, 8'h05);
    bus_wr(PWMPD_ADDR_DB_CTRL, 8'h02);
    bus_wr(PWMPD_ADDR_MOD_CTRL, 8'h88);
    wt(150);
    `CHK(rise_gap, 40)
    `CHK(high_len, 16)
    bus_wr(PWMPD_ADDR_DB_CTRL, 8'h00);
    $display("test dead band done");
    // Every mode and polarity with duty above period
    bus_wr(PWMPD_ADDR_DUTY_HI, 8'hff);
    for (int i = 0; i < 4; i++) begin
      bus_wr(PWMPD_ADDR_MOD_CTRL, 8'h00);
      bus_wr(PWMPD_ADDR_MOD_CTRL, 8'(8'h80 | (i << 2) | i));
      wt(200);
      `CHK(pins.oe, oe_t[i])
      `CHK(pins.level, (raw_t[i] ^ {i[0], i[1], i[0], i[1]}) & oe_t[i])
    end
    $display("test modes done");
    // Shutoff with software restart, then disabled trigger, then auto restart
    bus_wr(PWMPD_ADDR_MOD_CTRL, 8'h84);
    bus_wr(PWMPD_ADDR_SD_CTRL, 8'h14);
    wt(100);
    filt <= 1'b1;
    wt(10);
    bus_rd(PWMPD_ADDR_SD_CTRL, rd);
    `CHK(rd, 8'h94)
    `CHK(pins.level, 4'b0101)
    filt <= 1'b0;
    wt(20);
    bus_rd(PWMPD_ADDR_SD_CTRL, rd);
    `CHK(rd, 8'h94)
    bus_wr(PWMPD_ADDR_SD_CTRL, 8'h14);
    `CHK(pins.level, 4'b0101)
    wt(100);
    `CHK(pins.level, 4'b1001)
    bus_wr(PWMPD_ADDR_SD_CTRL, 8'h0b);
    filt <= 1'b1;
    wt(10);
    bus_rd(PWMPD_ADDR_SD_CTRL, rd);
    `CHK(rd, 8'h0b)
    `CHK(pins.level, 4'b1001)
    filt <= 1'b0;
    bus_wr(PWMPD_ADDR_DB_CTRL, 8'h80);
    bus_wr(PWMPD_ADDR_SD_CTRL, 8'h29);
    cmp <= 1'b1;
    wt(10);
    bus_rd(PWMPD_ADDR_SD_CTRL, rd);
    `CHK(rd, 8'ha9)
    `CHK(pins.level, 4'b1110)
    cmp <= 1'b0;
    wt(100);
    bus_rd(PWMPD_ADDR_SD_CTRL, rd);
    `CHK(rd, 8'h29)
    `CHK(pins.level, 4'b1001)
    $display("test shutoff done");
    tally_and_finish();
  end
endmodule : test_pwm_pulse_divider_gen

`default_nettype wire
